// ---- sqld_pkg.sv ----
// shared constants and types for the squib loop low level diagnostic logic
package sqld_pkg;
  localparam int CHANNELS      = 4;
  localparam int ADC_WIDTH     = 10;
  localparam int CMD_WIDTH     = 10;
  localparam int STATUS_WIDTH  = 7;
  localparam int ADC_CODE_WIDTH = 4;
  // request word field positions
  localparam int REQ_LEAK_CH_LO = 0;
  localparam int REQ_PIN        = 2;
  localparam int REQ_MONITOR    = 3;
  localparam int REQ_SOURCE     = 4;
  localparam int REQ_SINK       = 5;
  localparam int REQ_SRC_RET    = 6;
  localparam int REQ_PULLDOWN   = 7;
  localparam int REQ_RES_CH_LO  = 8;
  // config word field positions
  localparam int CFG_AUTO_OFF   = 0;
  // status word field positions
  localparam int STS_LEAK_CH_LO = 0;
  localparam int STS_PIN        = 2;
  localparam int STS_GND_SHORT  = 3;
  localparam int STS_BAT_SHORT  = 4;
  localparam int STS_HIGH_RESISTANCE_LOWER_FLAG     = 5;
  localparam int STS_HIGH_RESISTANCE_UPPER_FLAG     = 6;
  // reset values
  localparam logic [CMD_WIDTH-1:0] REQ_RESET = 10'h080;
  localparam logic                 CFG_RESET = 1'b0;
  // host register offsets
  localparam logic [2:0] OFS_REQUEST = 3'h0;
  localparam logic [2:0] OFS_CONTROL = 3'h1;
  localparam logic [2:0] OFS_CONFIG  = 3'h2;
  localparam logic [2:0] OFS_STATUS  = 3'h3;
  localparam logic [2:0] OFS_ADC     = 3'h4;
  typedef enum logic {PIN_FORWARD, PIN_RETURN} sqld_pin_type;
endpackage

// ---- sqld_link_if.sv ----
// command and result link between host controller and diagnostic logic
`timescale 1ns/10ps
`default_nettype none
interface sqld_link_if;
  import sqld_pkg::*;
  logic                    requestWrite;
  logic                    controlWrite;
  logic                    configWrite;
  logic [CMD_WIDTH-1:0]    commandData;
  logic [STATUS_WIDTH-1:0] loop_diag_result_reg;
  logic [ADC_WIDTH-1:0]    adcResult;
  logic                    adcFresh;
  modport device (input requestWrite, controlWrite, configWrite, commandData,
                  output loop_diag_result_reg, adcResult, adcFresh);
  modport host (output requestWrite, controlWrite, configWrite, commandData,
                input loop_diag_result_reg, adcResult, adcFresh);
endinterface
`default_nettype wire

// ---- sqld_device.sv ----
// diagnostic switch routing, status and ADC capture of the squib driver
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module sqld_device
  import sqld_pkg::*;
(
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      clockEnable,
  // command link
  sqld_link_if.device                    link,
  // global deployment state
  input  wire logic                      deploy_armed_state,
  // analog comparators, asynchronous
  input  wire logic                      batteryCompRaw,
  input  wire logic                      groundCompRaw,
  input  wire logic                      hsrUpperCompRaw,
  input  wire logic                      hsrLowerCompRaw,
  // converter
  output logic                           adcStart,
  output logic [ADC_CODE_WIDTH-1:0]      adc_request_code,
  input  wire logic                      adcDone,
  input  wire logic [ADC_WIDTH-1:0]      adcValue,
  // switch enables per channel
  output logic [CHANNELS-1:0]            sourceForward,
  output logic [CHANNELS-1:0]            sourceReturn,
  output logic [CHANNELS-1:0]            sinkReturn,
  output logic [CHANNELS-1:0]            monitorForward,
  output logic [CHANNELS-1:0]            monitorReturn,
  output logic [CHANNELS-1:0]            pulldownEnable
);

  logic [CMD_WIDTH-1:0]       loop_diag_request_reg;
  logic                       autoOff;
  logic [3:0]                 syncFirst;
  logic [3:0]                 syncSecond;
  logic                       adcBusy;
  logic                       battery_short_flag;
  logic                       ground_short_flag;
  logic                       high_resistance_upper_flag;
  logic                       high_resistance_lower_flag;
  logic [1:0]                 leakage_channel_select;
  logic [1:0]                 resistance_channel_select;
  sqld_pin_type               squib_pin_indicator;
  logic                       monitorOn;
  logic                       current_source_enable;
  logic                       current_sink_enable;
  logic                       sourceToReturn;
  logic                       pulldown_control;
  logic [CHANNELS-1:0]        next_sourceForward;
  logic [CHANNELS-1:0]        next_sourceReturn;
  logic [CHANNELS-1:0]        next_sinkReturn;
  logic [CHANNELS-1:0]        next_monitorForward;
  logic [CHANNELS-1:0]        next_monitorReturn;
  logic [CHANNELS-1:0]        next_pulldownEnable;

  // one-hot channel decode, used for every routed switch but the pulldowns, which take the inverse of the monitor return decode
  function automatic logic [CHANNELS-1:0] channelHot(input logic [1:0] ch, input logic on);
    logic [CHANNELS-1:0] hot;
    hot = '0;
    hot[ch] = on;
    return hot;
  endfunction

  // request fields
  assign leakage_channel_select    = loop_diag_request_reg[REQ_LEAK_CH_LO +: 2];
  assign squib_pin_indicator       = sqld_pin_type'(loop_diag_request_reg[REQ_PIN]);
  assign monitorOn                 = loop_diag_request_reg[REQ_MONITOR];
  assign current_source_enable     = loop_diag_request_reg[REQ_SOURCE];
  assign current_sink_enable       = loop_diag_request_reg[REQ_SINK];
  assign sourceToReturn            = loop_diag_request_reg[REQ_SRC_RET];
  assign pulldown_control          = loop_diag_request_reg[REQ_PULLDOWN];
  assign resistance_channel_select = loop_diag_request_reg[REQ_RES_CH_LO +: 2];

  // request register: each written step is held until the next one or the armed state; the
  // device only clears the source and sink bits itself, after a reading with autoOff set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loop_diag_request_reg <= REQ_RESET;
    end else if (clockEnable) begin
      if (deploy_armed_state) begin
        loop_diag_request_reg <= REQ_RESET;
      end else if (link.requestWrite) begin
        loop_diag_request_reg <= link.commandData;
      end else if (autoOff && adcBusy && adcDone) begin
        // a reading just finished: drop the measurement currents
        loop_diag_request_reg[REQ_SOURCE] <= 1'b0;
        loop_diag_request_reg[REQ_SINK]   <= 1'b0;
      end
    end
  end

  // configuration: automatic switch-off after ADC reading
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      autoOff <= CFG_RESET;
    end else if (clockEnable && link.configWrite) begin
      autoOff <= link.commandData[CFG_AUTO_OFF];
    end
  end

  // comparator synchronisers; only the second stage is read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncFirst  <= 4'h0;
      syncSecond <= 4'h0;
    end else if (clockEnable) begin
      syncFirst  <= {hsrUpperCompRaw, hsrLowerCompRaw, batteryCompRaw, groundCompRaw};
      syncSecond <= syncFirst;
    end
  end

  // flags are plain views of the comparators, no hold
  assign ground_short_flag          = syncSecond[0];
  assign battery_short_flag         = syncSecond[1];
  assign high_resistance_lower_flag = syncSecond[2];
  assign high_resistance_upper_flag = syncSecond[3];

  // status word: channel and pin under test plus live flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.loop_diag_result_reg <= '0;
    end else if (clockEnable) begin
      link.loop_diag_result_reg[STS_LEAK_CH_LO +: 2] <= leakage_channel_select;
      link.loop_diag_result_reg[STS_PIN]       <= squib_pin_indicator;
      link.loop_diag_result_reg[STS_GND_SHORT] <= ground_short_flag;
      link.loop_diag_result_reg[STS_BAT_SHORT] <= battery_short_flag;
      link.loop_diag_result_reg[STS_HIGH_RESISTANCE_LOWER_FLAG]    <= high_resistance_lower_flag;
      link.loop_diag_result_reg[STS_HIGH_RESISTANCE_UPPER_FLAG]    <= high_resistance_upper_flag;
    end
  end

  // switch routing decode
  always_comb begin
    next_monitorForward = channelHot(leakage_channel_select,
                                     monitorOn && squib_pin_indicator == PIN_FORWARD);
    next_monitorReturn  = channelHot(leakage_channel_select,
                                     monitorOn && squib_pin_indicator == PIN_RETURN);
    // source to forward for oxide, battery validation and step one
    next_sourceForward  = channelHot(resistance_channel_select,
                                     current_source_enable && !sourceToReturn);
    // offset step: source moved to the return pin, sink kept on
    next_sourceReturn   = channelHot(resistance_channel_select,
                                     current_source_enable && sourceToReturn);
    next_sinkReturn     = channelHot(resistance_channel_select, current_sink_enable);
    // the source may share the forward pin with the monitor, as battery
    // validation needs; one select bit keeps it off two pins at once, and the
    // sink only meets it on the return pin in the offset step
    // other return pins keep their pulldown the one under test drops
    // it the control bit cleared drops them all
    next_pulldownEnable = pulldown_control ? ~next_monitorReturn : '0;
    // validation steps drop the pulldowns by clearing the control bit
    if (deploy_armed_state) begin
      next_sourceForward  = '0;
      next_sourceReturn   = '0;
      next_sinkReturn     = '0;
      next_monitorForward = '0;
      next_monitorReturn  = '0;
      next_pulldownEnable = '0;
    end
  end

  // registered switch enables
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sourceForward  <= '0;
      sourceReturn   <= '0;
      sinkReturn     <= '0;
      monitorForward <= '0;
      monitorReturn  <= '0;
      pulldownEnable <= '0;
    end else if (clockEnable) begin
      sourceForward  <= next_sourceForward;
      sourceReturn   <= next_sourceReturn;
      sinkReturn     <= next_sinkReturn;
      monitorForward <= next_monitorForward;
      monitorReturn  <= next_monitorReturn;
      pulldownEnable <= next_pulldownEnable;
    end
  end

  // conversion request: one start pulse per control command, none while armed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adcStart         <= 1'b0;
      adc_request_code <= '0;
      adcBusy          <= 1'b0;
    end else if (clockEnable) begin
      adcStart <= 1'b0;
      if (deploy_armed_state) begin
        adcBusy          <= 1'b0;
        adc_request_code <= '0;
      end else if (link.controlWrite) begin
        // a new request restarts; the older one is abandoned
        adcStart         <= 1'b1;
        adc_request_code <= link.commandData[ADC_CODE_WIDTH-1:0];
        adcBusy          <= 1'b1;
      end else if (adcDone) begin
        adcBusy <= 1'b0;
      end
    end
  end

  // result capture; fresh is set by a completed reading and cleared by the
  // next request, a completion in that same cycle is dropped since
  // the request wins and restarts the converter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.adcResult <= '0;
      link.adcFresh  <= 1'b0;
    end else if (clockEnable) begin
      if (adcBusy && adcDone && !link.controlWrite) begin
        link.adcResult <= adcValue;
        link.adcFresh  <= 1'b1;
      end else if (link.controlWrite) begin
        link.adcFresh <= 1'b0;
      end
    end
  end

endmodule // sqld_device
`default_nettype wire

// ---- sqld_host.sv ----
// host end: software register port turned into diagnostic commands
`timescale 1ns/10ps
`default_nettype none
module sqld_host
  import sqld_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clockEnable,
  // software port
  input  wire logic [2:0]            address,
  input  wire logic [CMD_WIDTH-1:0]  writeData,
  input  wire logic                  writeStrobe,
  input  wire logic                  readStrobe,
  output logic [CMD_WIDTH-1:0]       readData,
  // command link
  sqld_link_if.host                  link
);

  // every software write to the request, control or config offset in a clockEnable cycle becomes exactly one command; the host end adds no
  // sequencing of its own, step order stays with software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.requestWrite <= 1'b0;
      link.controlWrite <= 1'b0;
      link.configWrite  <= 1'b0;
      link.commandData  <= REQ_RESET;
    end else if (clockEnable) begin
      link.requestWrite <= writeStrobe && address == OFS_REQUEST;
      link.controlWrite <= writeStrobe && address == OFS_CONTROL;
      link.configWrite  <= writeStrobe && address == OFS_CONFIG;
      if (writeStrobe) begin
        link.commandData <= writeData;
      end
    end
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readData <= '0;
    end else if (clockEnable) begin
      readData <= '0;
      if (readStrobe) begin
        case (address)
          OFS_STATUS: readData <= {3'h0, link.loop_diag_result_reg};
          OFS_ADC:    readData <= link.adcResult;
          default:    readData <= '0;
        endcase
      end
    end
  end

endmodule // sqld_host
`default_nettype wire

// ---- sqld_link_sva.sv ----
// concurrent checks on the link between host end and device end
`timescale 1ns/10ps
`default_nettype none
module sqld_link_sva
  import sqld_pkg::*;
(
  // clock, reset and armed state
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    deploy_armed_state,
  // link signals
  input wire logic                    requestWrite,
  input wire logic                    controlWrite,
  input wire logic                    configWrite,
  input wire logic [CMD_WIDTH-1:0]    commandData,
  input wire logic [STATUS_WIDTH-1:0] loop_diag_result_reg,
  input wire logic [ADC_WIDTH-1:0]    adcResult,
  input wire logic                    adcFresh
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  one_strobe_a: assert property ($onehot0({requestWrite, controlWrite, configWrite}))
    else $error("more than one link strobe in a cycle");
  reset_word_a: assert property ($fell(rst) |-> commandData == REQ_RESET)
    else $error("command word not at reset value after reset");
  fresh_clear_a: assert property (controlWrite |=> !adcFresh)
    else $error("result flag not cleared by a new conversion request");
  fresh_hold_a: assert property (adcFresh && !controlWrite && !deploy_armed_state |=> adcFresh)
    else $error("result flag dropped without a request");
  fresh_rise_a: assert property ($rose(adcFresh) |-> !$past(controlWrite))
    else $error("result flag rose right after a conversion request");
  result_cause_a: assert property (!$stable(adcResult) |-> $rose(adcFresh) || adcResult == '0)
    else $error("conversion result changed without completion");
  // the test fields only move after a request word or when forced back to reset
  field_cause_a: assert property (!$stable(loop_diag_result_reg[2:0]) |->
      $past(requestWrite) || $past(requestWrite, 2) || $past(requestWrite, 3) ||
      $past(requestWrite, 4) || loop_diag_result_reg[2:0] == 3'h0)
    else $error("channel or pin field changed without a request");
  armed_reset_a: assert property (deploy_armed_state [*3] |-> loop_diag_result_reg[2:0] == 3'h0)
    else $error("test selection not reset while armed");
endmodule // sqld_link_sva
`default_nettype wire

// ---- squib_loop_low_level_diag_test.sv ----
// self-checking bench joining host end and device end over the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) compare(32'(g), 32'(e))
module squib_loop_low_level_diag_test
  import sqld_pkg::*;
;
  logic                 clock;
  logic                 rst;
  logic                 clockEnable;
  logic [2:0]           address;
  logic [CMD_WIDTH-1:0] writeData;
  logic                 writeStrobe;
  logic                 readStrobe;
  logic [CMD_WIDTH-1:0] readData;
  logic                 deploy_armed_state;
  logic                 batteryCompRaw, groundCompRaw, hsrUpperCompRaw, hsrLowerCompRaw;
  logic                 adcStart;
  logic [3:0]           adc_request_code;
  logic                 adcDone;
  logic [ADC_WIDTH-1:0] adcValue;
  logic [3:0]           sourceForward, sourceReturn, sinkReturn;
  logic [3:0]           monitorForward, monitorReturn, pulldownEnable;
  int                   errTotal;
  int                   checksDone;
  logic [9:0]           w, d, v;
  logic [3:0]           cmp, k;
  logic                 cfg;
  int                   i, seed;
  logic [9:0]           expAdc[$];

  sqld_link_if link ();
  sqld_host i_sqld_host (.clock(clock), .rst(rst), .clockEnable(clockEnable),
    .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .link(link));
  sqld_device i_sqld_device (.clock(clock), .rst(rst), .clockEnable(clockEnable),
    .link(link), .deploy_armed_state(deploy_armed_state),
    .batteryCompRaw(batteryCompRaw), .groundCompRaw(groundCompRaw),
    .hsrUpperCompRaw(hsrUpperCompRaw), .hsrLowerCompRaw(hsrLowerCompRaw),
    .adcStart(adcStart), .adc_request_code(adc_request_code), .adcDone(adcDone),
    .adcValue(adcValue), .sourceForward(sourceForward), .sourceReturn(sourceReturn),
    .sinkReturn(sinkReturn), .monitorForward(monitorForward),
    .monitorReturn(monitorReturn), .pulldownEnable(pulldownEnable));
  sqld_link_sva i_sqld_link_sva (.clock(clock), .rst(rst),
    .deploy_armed_state(deploy_armed_state), .requestWrite(link.requestWrite),
    .controlWrite(link.controlWrite), .configWrite(link.configWrite),
    .commandData(link.commandData), .loop_diag_result_reg(link.loop_diag_result_reg),
    .adcResult(link.adcResult), .adcFresh(link.adcFresh));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [9:0] data);
    @(posedge clock);
    address <= a;
    writeData <= data;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [2:0] a, output logic [9:0] data);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 data = readData;
  endtask

  // reference routing: source and sink on the measurement channel, monitor on the leak channel
  task automatic check_switches(input logic [9:0] r);
    logic [3:0] lc, rc, mf, mr;
    lc = 4'h1 << r[1:0];
    rc = 4'h1 << r[9:8];
    mf = (r[3] && !r[2]) ? lc : 4'h0;
    mr = (r[3] && r[2]) ? lc : 4'h0;
    `CHK(monitorForward, mf);
    `CHK(monitorReturn, mr);
    `CHK(sourceForward, (r[4] && !r[6]) ? rc : 4'h0);
    `CHK(sourceReturn, (r[4] && r[6]) ? rc : 4'h0);
    `CHK(sinkReturn, r[5] ? rc : 4'h0);
    `CHK(pulldownEnable, r[7] ? 4'hf & ~mr : 4'h0);
    `CHK(sourceForward & sourceReturn, 4'h0);
  endtask

  // one step: request word and comparator levels, then switches and status
  task automatic step(input logic [9:0] r, input logic [3:0] c);
    wr(OFS_REQUEST, r);
    {batteryCompRaw, groundCompRaw, hsrUpperCompRaw, hsrLowerCompRaw} <= c;
    repeat (4) @(posedge clock);
    #1 check_switches(r);
    rd(OFS_STATUS, d);
    `CHK(d, {3'h0, c[1], c[0], c[3], c[2], r[2:0]});
  endtask

  task automatic tallyAndFinish;
    if (errTotal == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // about 550 cycles are needed; cut off far beyond that
  initial begin
    #2000000;
    errTotal++;
    tallyAndFinish();
  end

  initial begin
    {rst, clockEnable, address, writeData, writeStrobe, readStrobe} = {2'b11, 15'h0};
    {deploy_armed_state, batteryCompRaw, groundCompRaw, hsrUpperCompRaw} = 4'h0;
    {hsrLowerCompRaw, adcDone, adcValue} = 12'h0;
    errTotal = 0;
    checksDone = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    seed = $urandom(27);
    @(posedge clock);
    #1 check_switches(REQ_RESET);
    for (i = 0; i < 8; i++) begin
      if (i != 3 && i != 4) begin
        rd(3'(i), d);
        `CHK(d, 10'h000);
      end
    end
    wr(3'h6, 10'h3ff);
    repeat (4) @(posedge clock);
    #1 check_switches(REQ_RESET);
    // monitor validation, leakage run and rerun with every pulldown off
    step(10'h21a, 4'h8);
    step(10'h22e, 4'h4);
    step(10'h28e, 4'h4);
    step(10'h20e, 4'h0);
    for (i = 0; i < 24; i++) begin
      w = 10'($urandom);
      cfg = 1'($urandom);
      cmp = 4'($urandom);
      k = 4'($urandom);
      v = 10'($urandom);
      wr(OFS_CONFIG, {9'h0, cfg});
      step(w, cmp);
      wr(OFS_CONTROL, {6'h0, k});
      @(posedge clock);
      adcDone <= 1'b1;
      adcValue <= v;
      expAdc.push_back(v);
      #1 `CHK({adcStart, adc_request_code}, {1'b1, k});
      @(posedge clock);
      adcDone <= 1'b0;
      adcValue <= ~v;
      repeat (3) @(posedge clock);
      rd(OFS_ADC, d);
      `CHK(d, expAdc.pop_front());
      if (cfg) begin
        w[5:4] = 2'b00;
      end
      check_switches(w);
    end
    // clock enable low: strobes must leave no trace, comparator moves show in the status once it is high again
    @(posedge clock);
    clockEnable <= 1'b0;
    cmp = ~cmp;
    wr(OFS_REQUEST, 10'h03c);
    wr(OFS_CONTROL, 10'h005);
    {batteryCompRaw, groundCompRaw, hsrUpperCompRaw, hsrLowerCompRaw} <= cmp;
    repeat (4) @(posedge clock);
    #1 check_switches(w);
    `CHK({adcStart, adc_request_code}, {1'b0, k});
    @(posedge clock);
    clockEnable <= 1'b1;
    repeat (4) @(posedge clock);
    rd(OFS_STATUS, d);
    `CHK(d, {3'h0, cmp[1], cmp[0], cmp[3], cmp[2], w[2:0]});
    @(posedge clock);
    deploy_armed_state <= 1'b1;
    wr(OFS_REQUEST, 10'h3ff);
    repeat (4) @(posedge clock);
    #1 `CHK({sourceForward, sourceReturn, sinkReturn, monitorForward}, 16'h0);
    `CHK({monitorReturn, pulldownEnable}, 8'h0);
    `CHK(adc_request_code, 4'h0);
    @(posedge clock);
    deploy_armed_state <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check_switches(REQ_RESET);
    tallyAndFinish();
  end
endmodule // squib_loop_low_level_diag_test
`default_nettype wire
